// ---- inc/ccr_pkg.sv ----
/*
 * Constants, field layouts, reset values and decode helpers shared by the
 * converter configuration register bank and its serial port engine.
 * Assumes a single 100 MHz clock domain and a synchronous active-high reset.
 */
// Notes on behaviour
// - The address space splits into chip setup 0x00-0x02, commit 0xff, converter functions 0x08-0x3a, link setup 0x60-0x78.
// - Every location is one byte, bit 7 being the most significant bit of its default value.
// - Any reset, hardware or soft, reloads the configuration registers with their defaults.
// - Locations 0x08-0x3a and 0x60-0x78 are double buffered and host writes reach only the shadow copy.
// - Writing 0x01 to 0xff copies every shadow byte into its active copy together, one cycle after the write strobe.
// - The commit bit clears itself after the copy so later reads return zero.
// - The input span select location 0x18 resets to 0x00, the default 1.75 V p-p span.
// - Serial transfers are most significant bit first after power-up, changed only through the port setup byte.
// - Each access opens with a 16-bit instruction whose bit 15 selects read or write, then byte-wide data words.
package ccr_pkg;

	localparam int ADDR_W       = 13;
	localparam int DATA_W       = 8;
	localparam int INSTR_W      = 16;
	localparam int IDX_W        = 7;
	localparam int FUNC_COUNT   = 51;
	localparam int LINK_COUNT   = 25;
	localparam int SHADOW_COUNT = 76;

	// register offsets and region bounds
	localparam logic [12:0] OFS_PORT_SETUP  = 13'h000;
	localparam logic [12:0] OFS_PART_ID     = 13'h001;
	localparam logic [12:0] OFS_SPEED_GRADE = 13'h002;
	localparam logic [12:0] OFS_POWER       = 13'h008;
	localparam logic [12:0] OFS_GLOBAL_CLK  = 13'h009;
	localparam logic [12:0] OFS_OUTPUT_MODE = 13'h014;
	localparam logic [12:0] OFS_SPAN_SELECT = 13'h018;
	localparam logic [12:0] OFS_COMMIT      = 13'h0ff;
	localparam logic [12:0] FUNC_LO         = 13'h008;
	localparam logic [12:0] FUNC_HI         = 13'h03a;
	localparam logic [12:0] LINK_LO         = 13'h060;
	localparam logic [12:0] LINK_HI         = 13'h078;

	// reset values
	localparam logic [7:0] PORT_SETUP_RESET  = 8'h18;
	localparam logic [7:0] POWER_RESET       = 8'h00;
	localparam logic [7:0] GLOBAL_CLK_RESET  = 8'h01;
	localparam logic [7:0] OUTPUT_MODE_RESET = 8'h01;
	localparam logic [7:0] SPAN_RESET        = 8'h00;
	localparam logic [7:0] OTHER_RESET       = 8'h00;
	localparam logic [7:0] COMMIT_RESET      = 8'h00;

	// field positions
	localparam int PS_LSB_HI   = 6;
	localparam int PS_SRST_HI  = 5;
	localparam int PS_SRST_LO  = 2;
	localparam int PS_LSB_LO   = 1;
	localparam int COMMIT_BIT  = 0;
	localparam int PWR_PIN_SEL = 5;
	localparam int GRADE_LO    = 4;
	localparam int INSTR_RW    = 15;
	localparam int INSTR_LEN_L = 13;

	localparam logic [1:0] PWR_NORMAL = 2'b00;
	localparam logic [1:0] PWR_FULL   = 2'b01;
	localparam logic [1:0] PWR_HOLD   = 2'b10;
	localparam logic [1:0] LEN_STREAM = 2'b11;

	typedef enum logic [1:0] {
		SP_INSTR,
		SP_DATA,
		SP_DONE
	} ccr_port_state_type;

	// true for a location held in the shadow/active pair
	function automatic logic in_shadow(input logic [12:0] a);
		return (a >= FUNC_LO && a <= FUNC_HI) || (a >= LINK_LO && a <= LINK_HI);
	endfunction

	// packs both shadowed regions into one dense index
	function automatic logic [6:0] shadow_index(input logic [12:0] a);
		logic [12:0] d;
		d = (a >= LINK_LO) ? (a - LINK_LO + 13'(FUNC_COUNT)) : (a - FUNC_LO);
		return d[6:0];
	endfunction

	// default of a shadowed location
	function automatic logic [7:0] shadow_default(input int idx);
		logic [12:0] a;
		a = (idx >= FUNC_COUNT) ? 13'(idx - FUNC_COUNT) + LINK_LO : 13'(idx) + FUNC_LO;
		case (a)
			OFS_POWER:       return POWER_RESET;
			OFS_GLOBAL_CLK:  return GLOBAL_CLK_RESET;
			OFS_OUTPUT_MODE: return OUTPUT_MODE_RESET;
			OFS_SPAN_SELECT: return SPAN_RESET;
			default:         return OTHER_RESET;
		endcase
	endfunction

endpackage

// ---- verilog/ccr_serial_port.sv ----
/*
 * Three-wire serial control port engine: framing, instruction decode,
 * byte assembly and readback drive of the shared data pin.
 * Assumes sclk, sdio and the select line are asynchronous to mclk and that
 * sclk runs well below mclk / 8 so every edge is seen after synchronising.
 */
`timescale 1ns/1ps
module ccr_serial_port (
	input  wire logic               mclk,        // system clock
	input  wire logic               rst,         // synchronous reset
	input  wire logic               sclk,        // serial clock pin
	input  wire logic               select_active_low, // frame select pin
	input  wire logic               sdio_in,     // data pin, input side
	output logic                    sdio_out,    // data pin, output side
	output logic                    sdio_oe,     // data pin drive enable
	input  wire logic               lsb_first,   // bit order select
	output logic [ccr_pkg::ADDR_W-1:0] addr,     // current register address
	output logic [7:0]              wdata,       // byte to write
	output logic                    wr_stb,      // one-cycle write strobe
	input  wire logic [7:0]         rdata        // byte at addr
);
	import ccr_pkg::*;

	logic [2:0]         sclk_sync;
	logic [1:0]         sel_sync;
	logic [1:0]         din_sync;
	ccr_port_state_type state;
	logic [3:0]         bit_cnt;
	logic [15:0]        shreg;
	logic               is_read;
	logic [1:0]         len;
	logic [1:0]         byte_cnt;
	logic [7:0]         out_byte;

	wire                rise      = sclk_sync[1] & ~sclk_sync[2];
	wire                fall      = ~sclk_sync[1] & sclk_sync[2];
	wire                idle      = sel_sync[1];
	wire                din       = din_sync[1];
	wire [15:0]         next_shreg = lsb_first ? {din, shreg[15:1]} : {shreg[14:0], din};
	wire [15:0]         instr     = next_shreg;
	wire [7:0]          in_byte   = lsb_first ? next_shreg[15:8] : next_shreg[7:0];
	wire [2:0]          out_pos   = lsb_first ? bit_cnt[2:0] : 3'(7 - bit_cnt[2:0]);
	wire                last_byte = (len != LEN_STREAM) && (byte_cnt == len);
	wire [12:0]         next_addr = lsb_first ? addr + 13'h001 : addr - 13'h001;

	// pins pass two flops; the third stage only feeds edge detection
	always_ff @(posedge mclk) begin
		sclk_sync <= {sclk_sync[1:0], sclk};
		sel_sync  <= {sel_sync[0], select_active_low};
		din_sync  <= {din_sync[0], sdio_in};
	end

	always_ff @(posedge mclk) begin
		wr_stb <= 1'b0;
		if (rst || idle) begin
			state    <= SP_INSTR;
			bit_cnt  <= 4'h0;
			byte_cnt <= 2'b00;
			shreg    <= 16'h0000;
			is_read  <= 1'b0;
			len      <= 2'b00;
			addr     <= 13'h0000;
			wdata    <= 8'h00;
		end else if (rise) begin
			shreg   <= next_shreg;
			bit_cnt <= bit_cnt + 4'h1;
			case (state)
				SP_INSTR: begin
					if (bit_cnt == 4'hf) begin
						state   <= SP_DATA;
						bit_cnt <= 4'h0;
						is_read <= instr[INSTR_RW];
						len     <= instr[INSTR_LEN_L +: 2];
						addr    <= instr[ADDR_W-1:0];
					end
				end
				SP_DATA: begin
					if (bit_cnt == 4'h7) begin
						bit_cnt  <= 4'h0;
						byte_cnt <= byte_cnt + 2'b01;
						wdata    <= in_byte;
						wr_stb   <= ~is_read;
						if (last_byte)
							state <= SP_DONE;
						else
							addr <= next_addr;
					end
				end
				SP_DONE: bit_cnt <= 4'h0;
				default: state <= SP_INSTR;
			endcase
		end
	end

	// readback byte captured at each byte start; driven bit steps on falling sclk
	always_ff @(posedge mclk) begin
		if (rst || idle) begin
			out_byte <= 8'h00;
			sdio_out <= 1'b0;
			sdio_oe  <= 1'b0;
		end else begin
			if (state == SP_DATA && bit_cnt == 4'h0 && !rise)
				out_byte <= rdata;
			if (fall || !sdio_oe)
				sdio_out <= out_byte[out_pos];
			sdio_oe <= is_read && (state == SP_DATA);
		end
	end

	// a write strobe lands on the same edge as the addr advance, so for every byte but the last
	// the strobe sees the next address; only the last byte keeps its own (addr holds there)
endmodule

// ---- verilog/ccr_register_bank.sv ----
/*
 * Configuration register bank of a serial-output converter: chip setup,
 * identification, speed grade, commit register and the double-buffered
 * converter function and link setup locations, with power mode decode.
 * Assumes the serial host keeps the framing of the three-wire port and that
 * the power-down pin is asynchronous to mclk.
 */
`timescale 1ns/1ps
module ccr_register_bank #(
	parameter logic [7:0] PART_ID    = 8'h5a,    // arbitrary identification value
	parameter logic [1:0] GRADE_CODE = 2'b10     // arbitrary speed grade value
) (
	input  wire logic                  mclk,              // system clock, 100 MHz
	input  wire logic                  rst,               // synchronous reset, active high
	input  wire logic                  sclk,              // serial clock pin
	input  wire logic                  select_active_low, // serial frame select, low active
	input  wire logic                  sdio_in,           // serial data pin, input side
	output logic                       sdio_out,          // serial data pin, output side
	output logic                       sdio_oe,           // serial data pin drive enable
	input  wire logic                  power_down_pin,    // external power-down pin
	output logic                       full_power_down,   // converter fully powered down
	output logic                       low_power_hold,    // converter in standby
	output logic                       lsb_first,         // serial bit order in force
	output logic                       commit_pulse,      // one-cycle shadow to active copy
	output logic [ccr_pkg::SHADOW_COUNT*8-1:0] active_image // active copies, index 0 in low byte
);
	import ccr_pkg::*;

	logic [7:0]  shadow [SHADOW_COUNT];
	logic [7:0]  active [SHADOW_COUNT];
	logic        soft_reset;
	logic        commit_bit;
	logic [1:0]  pin_sync;
	logic [12:0] addr;
	logic [7:0]  wdata;
	logic        wr_stb;
	logic [7:0]  rdata;

	// serial protocol engine
	ccr_serial_port u_port (
		.mclk              (mclk),
		.rst               (rst),
		.sclk              (sclk),
		.select_active_low (select_active_low),
		.sdio_in           (sdio_in),
		.sdio_out          (sdio_out),
		.sdio_oe           (sdio_oe),
		.lsb_first         (lsb_first),
		.addr              (addr),
		.wdata             (wdata),
		.wr_stb            (wr_stb),
		.rdata             (rdata)
	);

	wire         hit_port   = (addr == OFS_PORT_SETUP);
	wire         hit_id     = (addr == OFS_PART_ID);
	wire         hit_grade  = (addr == OFS_SPEED_GRADE);
	wire         hit_commit = (addr == OFS_COMMIT);
	wire         hit_shadow = in_shadow(addr);
	wire [6:0]   sh_idx     = shadow_index(addr);

	wire         wr_port    = wr_stb && hit_port;
	wire         wr_commit  = wr_stb && hit_commit;
	wire         wr_shadow  = wr_stb && hit_shadow;

	wire         reload     = rst || soft_reset;

	// mirrored flags, either nibble sets them
	wire         wr_lsb     = wdata[PS_LSB_HI] | wdata[PS_LSB_LO];
	wire         wr_srst    = wdata[PS_SRST_HI] | wdata[PS_SRST_LO];
	wire [7:0]   port_image = {1'b0, lsb_first, soft_reset, 1'b1, 1'b1, soft_reset, lsb_first, 1'b0};

	// byte-wide read image, unsupported locations read zero
	wire [7:0]   grade_image = 8'({GRADE_CODE, 4'h0});
	wire [7:0]   commit_image = 8'({commit_bit});
	assign rdata = hit_port   ? port_image :
	               hit_id     ? PART_ID :
	               hit_grade  ? grade_image :
	               hit_commit ? commit_image :
	               hit_shadow ? shadow[sh_idx] : 8'h00;

	// port setup flags; soft reset is self-clearing
	always_ff @(posedge mclk) begin
		if (rst) begin
			lsb_first  <= PORT_SETUP_RESET[PS_LSB_LO];
			soft_reset <= PORT_SETUP_RESET[PS_SRST_LO];
		end else if (soft_reset) begin
			lsb_first  <= PORT_SETUP_RESET[PS_LSB_LO];
			soft_reset <= 1'b0;
		end else if (wr_port) begin
			lsb_first  <= wr_lsb;
			soft_reset <= wr_srst;
		end
	end

	// commit bit set by host write of bit 0
	always_ff @(posedge mclk) begin
		if (reload)
			commit_bit <= COMMIT_RESET[COMMIT_BIT];
		else if (wr_commit && wdata[COMMIT_BIT])
			commit_bit <= 1'b1;
		else if (commit_bit)
			commit_bit <= 1'b0;
	end

	assign commit_pulse = commit_bit;

	// shadow and active pairs; each slot is its own little process
	genvar gi;
	generate
		for (gi = 0; gi < SHADOW_COUNT; gi++) begin : g_slot
			// span select and all others load defaults
			always_ff @(posedge mclk) begin
				if (reload)
					shadow[gi] <= shadow_default(gi);
				else if (wr_shadow && sh_idx == 7'(gi))
					shadow[gi] <= wdata;
			end
			always_ff @(posedge mclk) begin
				if (reload)
					active[gi] <= shadow_default(gi);
				else if (commit_bit)
					active[gi] <= shadow[gi];
			end
			assign active_image[gi*8 +: 8] = active[gi];
		end
	endgenerate

	// power-down pin is asynchronous, so two flops before the decode
	always_ff @(posedge mclk) begin
		if (rst)
			pin_sync <= 2'b00;
		else
			pin_sync <= {pin_sync[0], power_down_pin};
	end

	// mode decode from the active power byte and the synchronised pin
	wire [7:0]   power_act  = active[shadow_index(OFS_POWER)];
	wire [1:0]   power_mode = power_act[1:0];
	wire         pin_hold   = power_act[PWR_PIN_SEL];
	wire         next_full  = (power_mode == PWR_FULL) || (pin_sync[1] && !pin_hold);
	wire         next_hold  = !next_full && ((power_mode == PWR_HOLD) || (pin_sync[1] && pin_hold));

	// registered so the converter sees glitch-free power controls
	always_ff @(posedge mclk) begin
		if (rst) begin
			full_power_down <= 1'b0;
			low_power_hold  <= 1'b0;
		end else begin
			full_power_down <= next_full;
			low_power_hold  <= next_hold;
		end
	end

	// identification and grade are fixed, so writes to them fall through;
	// the host keeps open bits zero and leaves fully open locations alone,
	// so stored open bits are not masked here (saves a per-slot mask table)
	// relies on host zeroing
endmodule

// ---- tb/ccr_properties.sv ----
/*
 * Port-level checks of the converter configuration register bank.
 * Assumes it is bound to the bank top and sees only its ports.
 */
`timescale 1ns/1ps
module ccr_properties (
	input wire logic                                mclk,              // system clock
	input wire logic                                rst,               // synchronous reset
	input wire logic                                sclk,              // serial clock pin
	input wire logic                                select_active_low, // frame select
	input wire logic                                sdio_oe,           // data pin drive enable
	input wire logic                                power_down_pin,    // external power-down pin
	input wire logic                                full_power_down,   // full power-down state
	input wire logic                                low_power_hold,    // standby state
	input wire logic                                commit_pulse,      // shadow copy strobe
	input wire logic [ccr_pkg::SHADOW_COUNT*8-1:0] active_image       // active copies
);
	import ccr_pkg::*;
	localparam logic [SHADOW_COUNT*8-1:0] DEF = ({{(SHADOW_COUNT*8-8){1'b0}}, GLOBAL_CLK_RESET} << 8)
		| ({{(SHADOW_COUNT*8-8){1'b0}}, OUTPUT_MODE_RESET} << 96);
	logic [7:0] pwr;
	logic       exp_full;
	logic       exp_hold;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// power state expected from active mode byte and pin
	assign pwr      = active_image[7:0];
	assign exp_full = (pwr[1:0] == PWR_FULL) || (power_down_pin && !pwr[PWR_PIN_SEL]);
	assign exp_hold = !exp_full && ((pwr[1:0] == PWR_HOLD) || (power_down_pin && pwr[PWR_PIN_SEL]));

	a_commit_one_cycle: assert property (commit_pulse |=> !commit_pulse)
		else $error("commit strobe longer than one cycle");
	// active copies load on the edge that ends the strobe; soft reset only brings back defaults
	a_image_commit_only: assert property ($changed(active_image) |->
		$past(commit_pulse) || $past(rst) || active_image == DEF)
		else $error("active copy changed without commit");
	a_reset_defaults: assert property ($fell(rst) |-> active_image == DEF)
		else $error("active copies not at defaults after reset");
	a_pd_full_state: assert property (($stable(power_down_pin) && $stable(pwr))[*6] |-> full_power_down == exp_full)
		else $error("full power-down state wrong");
	a_pd_hold_state: assert property (($stable(power_down_pin) && $stable(pwr))[*6] |-> low_power_hold == exp_hold)
		else $error("standby state wrong");
	a_pd_exclusive: assert property (!(full_power_down && low_power_hold))
		else $error("both power states at once");
	a_oe_select_idle: assert property (select_active_low[*6] |-> !sdio_oe)
		else $error("data pin driven outside a frame");
	a_oe_after_instr: assert property ($rose(sdio_oe) |-> sclk && $past(sclk, 3))
		else $error("read drive not after an instruction clock rise");
	a_commit_on_clock: assert property ($rose(commit_pulse) |-> !select_active_low && $past(sclk, 3))
		else $error("commit outside a data clock rise");
endmodule

// ---- tb/ccr_host_model.sv ----
/*
 * Serial control host: three-wire frames, one byte each, in either bit order.
 * Assumes the bench resolves the shared data pin and feeds it back.
 */
`timescale 1ns/1ps
module ccr_host_model (
	input  wire logic mclk,              // system clock, paces the serial clock
	input  wire logic sdio,              // resolved data pin level
	output logic      sclk,              // serial clock, still between frames
	output logic      select_active_low, // frame select
	output logic      host_data          // host drive of the data pin
);
	// idle: no frame, clock low
	initial begin
		sclk = 1'b0;
		select_active_low = 1'b1;
		host_data = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// instruction then byte, in the order the bench has set in the port setup byte
	task automatic xfer(input logic lsb, input logic rd, input logic [12:0] a, input logic [7:0] wd,
		output logic [7:0] q);
		logic [15:0] ins;
		int          k;
		logic        dat;
		ins = {rd, 2'b00, a};
		q = 8'h00;
		tick(1);
		select_active_low = 1'b0;
		tick(5);
		for (int j = 0; j < 24; j++) begin
			dat = (j >= 16);
			k = dat ? (lsb ? j - 16 : 23 - j) : (lsb ? j : 15 - j);
			// released line shows the inverse so stale data cannot pass
			host_data = (rd && dat) ? ~host_data : (dat ? wd[k] : ins[k]);
			tick(10);
			sclk = 1'b1;
			if (rd && dat)
				q[k] = sdio;
			tick(10);
			sclk = 1'b0;
		end
		tick(1);
		select_active_low = 1'b1;
		host_data = ~host_data;
		tick(5);
	endtask
endmodule

// ---- tb/tb.sv ----
/*
 * Self-checking bench of the register bank, driven through the host model.
 * Assumes the bank answers within the serial timing of the host model.
 */
`timescale 1ns/1ps
module tb;
	import ccr_pkg::*;
	localparam logic [7:0] ID    = 8'h6b; // arbitrary identification value
	localparam logic [1:0] GRADE = 2'b10; // arbitrary speed grade value
	logic                      mclk, rst, sclk, select_active_low, sdio_in, sdio_out, sdio_oe;
	logic                      power_down_pin, full_power_down, low_power_hold, lsb_first;
	logic                      commit_pulse, host_data, host_lsb;
	logic [SHADOW_COUNT*8-1:0] active_image;
	int                        err_count, samples_checked, cycles;
	logic [7:0]                pv [5] = '{8'h01, 8'h02, 8'h00, 8'h20, 8'h00};
	logic                      pp [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [1:0]                pe [5] = '{2'b10, 2'b01, 2'b10, 2'b01, 2'b00};

	// shared pin: the bank's drive wins while sdio_oe is high, else the host level
	assign sdio_in = sdio_oe ? sdio_out : host_data;

	ccr_register_bank #(.PART_ID(ID), .GRADE_CODE(GRADE)) i_ccr_register_bank (.mclk(mclk), .rst(rst),
		.sclk(sclk), .select_active_low(select_active_low), .sdio_in(sdio_in), .sdio_out(sdio_out),
		.sdio_oe(sdio_oe), .power_down_pin(power_down_pin), .full_power_down(full_power_down),
		.low_power_hold(low_power_hold), .lsb_first(lsb_first), .commit_pulse(commit_pulse),
		.active_image(active_image));
	ccr_host_model host (.mclk(mclk), .sdio(sdio_in), .sclk(sclk), .select_active_low(select_active_low),
		.host_data(host_data));

	always #5 mclk = ~mclk;

	// hang guard, well above the ~15k cycles of the sequence
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			report_and_stop();
		end
	end

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.xfer(host_lsb, 1'b0, a, d, q);
	endtask

	task automatic rdc(input string what, input logic [12:0] a, input logic [7:0] exp);
		logic [7:0] q;
		host.xfer(host_lsb, 1'b1, a, 8'h00, q);
		check(what, exp, q);
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		power_down_pin = 1'b0;
		host_lsb = 1'b0;
		err_count = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (16) @(posedge mclk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		check("bit order", 8'h00, {7'h00, lsb_first});
		check("span active", SPAN_RESET, active_image[8*16 +: 8]);
		check("clock active", GLOBAL_CLK_RESET, active_image[8*1 +: 8]);
		rdc("port setup", OFS_PORT_SETUP, PORT_SETUP_RESET);
		rdc("part id", OFS_PART_ID, ID);
		rdc("grade", OFS_SPEED_GRADE, {2'b00, GRADE, 4'h0});
		rdc("span", OFS_SPAN_SELECT, SPAN_RESET);
		rdc("commit", OFS_COMMIT, COMMIT_RESET);
		rdc("unmapped", 13'h013, 8'h00); // fully open location is only read, never written
		wr(OFS_PART_ID, 8'h00);
		rdc("part id kept", OFS_PART_ID, ID);
		// lsb first: the mirrored flags land whatever the shift order
		wr(OFS_PORT_SETUP, 8'h5a);
		host_lsb = 1'b1;
		check("bit order lsb", 8'h01, {7'h00, lsb_first});
		rdc("port setup lsb", OFS_PORT_SETUP, 8'h5a);
		rdc("part id lsb", OFS_PART_ID, ID);
		wr(OFS_SPAN_SELECT, 8'h05);
		rdc("span staged lsb", OFS_SPAN_SELECT, 8'h05);
		check("span held", SPAN_RESET, active_image[8*16 +: 8]);
		wr(OFS_PORT_SETUP, 8'h3c);
		host_lsb = 1'b0;
		check("bit order back", 8'h00, {7'h00, lsb_first});
		rdc("port setup after", OFS_PORT_SETUP, PORT_SETUP_RESET);
		rdc("span reloaded", OFS_SPAN_SELECT, SPAN_RESET);
		// staged values with open bits zeroed stay out of force
		wr(OFS_GLOBAL_CLK, 8'h00);
		wr(OFS_OUTPUT_MODE, 8'h16);
		check("staged clock", GLOBAL_CLK_RESET, active_image[8*1 +: 8]);
		check("staged output", OUTPUT_MODE_RESET, active_image[8*12 +: 8]);
		wr(OFS_COMMIT, 8'h01);
		check("clock in force", 8'h00, active_image[8*1 +: 8]);
		check("output in force", 8'h16, active_image[8*12 +: 8]);
		rdc("commit clears", OFS_COMMIT, 8'h00);
		// soft reset must also bring the active copies back to their defaults
		wr(OFS_PORT_SETUP, 8'h3c);
		check("clock after soft reset", GLOBAL_CLK_RESET, active_image[8*1 +: 8]);
		check("output after soft reset", OUTPUT_MODE_RESET, active_image[8*12 +: 8]);
		// every mode and both pin functions
		for (int i = 0; i < 5; i++) begin
			power_down_pin = pp[i];
			wr(OFS_POWER, pv[i]);
			wr(OFS_COMMIT, 8'h01);
			repeat (6) @(posedge mclk);
			#1;
			check("power state", {6'h00, pe[i]}, {6'h00, full_power_down, low_power_hold});
		end
		report_and_stop();
	end
endmodule

bind ccr_register_bank ccr_properties i_ccr_properties (.mclk(mclk), .rst(rst), .sclk(sclk),
	.select_active_low(select_active_low), .sdio_oe(sdio_oe), .power_down_pin(power_down_pin),
	.full_power_down(full_power_down), .low_power_hold(low_power_hold), .commit_pulse(commit_pulse),
	.active_image(active_image));
